//--- hdl/formatted_bcd_arith_defs.svh
/*
  Constants of the formatted BCD arithmetic unit: operand counts, field
  positions, reset values and digit counts.
  Assumes it is included by its bare name from the package and the modules.
*/
`ifndef FORMATTED_BCD_ARITH_DEFS_SVH
`define FORMATTED_BCD_ARITH_DEFS_SVH

// Legal discrete-bit counts
`define FBA_CNT_MIN 6'd1
`define FBA_CNT_MAX_WIDE 6'd32
`define FBA_CNT_MAX_NARROW 6'd16

// Accumulator and stack reset values
`define FBA_ACC_RST 32'h0000_0000
`define FBA_STK_RST 32'h0000_0000

// Digit layout
`define FBA_DIGITS 8
`define FBA_DIGIT_W 4
`define FBA_LOW_DIGIT_TOP 2'h3
`define FBA_HALF_DIGIT 3

// Largest decimal digit
`define FBA_MAX_DIGIT 4'h9

`endif

//--- hdl/formatted_bcd_arith_pkg.sv
/*
  Types of the formatted BCD arithmetic unit: operation codes, sequencer
  states, command and flag carriers.
  Assumes the constants header sits beside it.
*/
`include "formatted_bcd_arith_defs.svh"

package formatted_bcd_arith_pkg;

    // Formatted operations
    typedef enum logic [1:0] {
        OP_ADD_FROM_BITS,
        OP_SUB_FROM_BITS,
        OP_MUL_FROM_BITS,
        OP_DIV_FROM_BITS
    } op_t;

    // Sequencer states
    typedef enum logic [3:0] {
        S_IDLE,
        S_REQ,
        S_CAP,
        S_EXEC,
        S_MUL_SH,
        S_MUL_ADD,
        S_DIV_SH,
        S_DIV_SUB,
        S_FIN
    } state_t;

    // Command from the instruction sequencer
    typedef struct packed {
        op_t op;
        logic [15:0] bit_addr;
        logic [5:0] bit_cnt;
    } cmd_t;

    // Status flags
    typedef struct packed {
        logic zero_flag;
        logic negative_flag;
        logic carry16_flag;
        logic carry32_flag;
        logic borrow16_flag;
        logic borrow32_flag;
        logic bad_bcd_flag;
    } flags_t;

endpackage : formatted_bcd_arith_pkg

//--- hdl/bcd_add32.sv
/*
  Eight-digit ripple BCD adder/subtractor, purely combinational.
  Assumes valid BCD inputs for a meaningful sum; bad digits still give a
  defined result. Subtraction is ten's complement, carry high means no borrow.
*/
`timescale 1ns/1ps
`default_nettype none
`include "formatted_bcd_arith_defs.svh"

module bcd_add32
    import formatted_bcd_arith_pkg::*;
(
    // Operands
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    input wire logic sub_i,
    // Results
    output logic [31:0] sum_o,
    output logic cout16_o,
    output logic cout32_o
);

    logic [`FBA_DIGITS:0] carry;

    // Subtraction enters with carry one for ten's complement
    assign carry[0] = sub_i;

    // One decimal digit stage per nibble
    genvar g;
    generate
        for (g = 0; g < `FBA_DIGITS; g = g + 1) begin : g_digit
            logic [3:0] bd;
            logic [4:0] raw;
            logic [4:0] fix;
            assign bd = sub_i ? (`FBA_MAX_DIGIT - b_i[4*g +: 4]) : b_i[4*g +: 4];
            assign raw = {1'b0, a_i[4*g +: 4]} + {1'b0, bd} + {4'h0, carry[g]};
            assign fix = (raw > 5'h09) ? (raw + 5'h06) : raw;
            assign sum_o[4*g +: 4] = fix[3:0];
            assign carry[g+1] = (raw > 5'h09);
        end
    endgenerate

    assign cout16_o = carry[`FBA_HALF_DIGIT + 1];
    assign cout32_o = carry[`FBA_DIGITS];

endmodule : bcd_add32

`default_nettype wire

//--- hdl/formatted_bcd_arith_unit.sv
/*
  Formatted BCD arithmetic unit: add, subtract, multiply and divide with a
  second operand gathered from consecutive discrete bits.
  Assumes a discrete bit memory on the same clock that answers a read one
  cycle after the read enable, and an instruction sequencer that waits for
  done before fetching the next instruction's operands.
*/
`timescale 1ns/1ps
`default_nettype none
`include "formatted_bcd_arith_defs.svh"

module formatted_bcd_arith_unit
    import formatted_bcd_arith_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Command from the sequencer
    input wire logic start_i,
    input wire cmd_t cmd_i,
    output logic busy_o,
    output logic done_o,
    output logic illegal_o,
    // Accumulator load from the sequencer
    input wire logic acc_load_i,
    input wire logic [31:0] acc_load_data_i,
    output logic [31:0] acc_o,
    // Discrete bit memory read port
    output logic bit_rd_en_o,
    output logic [ADDR_W-1:0] bit_rd_addr_o,
    input wire logic bit_rd_data_i,
    // First stack level write
    output logic stack_wr_o,
    output logic [31:0] stack_data_o,
    // Status flags
    output flags_t flags_o
);

    // Whole state of the block
    typedef struct packed {
        state_t st;
        op_t op;
        logic [ADDR_W-1:0] base;
        logic [5:0] cnt;
        logic [5:0] idx;
        logic [31:0] opnd;
        logic [31:0] acc;
        logic [31:0] work;
        logic [15:0] quo;
        logic [1:0] dig;
        logic [3:0] rep;
        logic busy;
        logic done;
        logic illegal;
        logic rd_en;
        logic [ADDR_W-1:0] rd_addr;
        logic stk_wr;
        logic [31:0] stk_data;
        flags_t flags;
    } unit_state_t;

    unit_state_t r;
    unit_state_t r_nxt;

    // Adder shared by all operations
    logic [31:0] add_a;
    logic [31:0] add_b;
    logic add_sub;
    logic [31:0] add_sum;
    logic add_c16;
    logic add_c32;

    bcd_add32 u_add (
        .a_i(add_a),
        .b_i(add_b),
        .sub_i(add_sub),
        .sum_o(add_sum),
        .cout16_o(add_c16),
        .cout32_o(add_c32)
    );

    // True when every nibble holds a decimal digit
    function automatic logic is_bcd32(input logic [31:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < `FBA_DIGITS; i++) begin
            if (v[4*i +: 4] > `FBA_MAX_DIGIT) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : is_bcd32

    // Legal bit count for the given operation
    function automatic logic cnt_ok(input op_t op, input logic [5:0] cnt);
        logic [5:0] top;
        top = (op == OP_ADD_FROM_BITS || op == OP_SUB_FROM_BITS) ?
              `FBA_CNT_MAX_WIDE : `FBA_CNT_MAX_NARROW;
        return (cnt >= `FBA_CNT_MIN) && (cnt <= top);
    endfunction : cnt_ok

    // Digit of a 16-bit value picked by the digit index
    function automatic logic [3:0] digit_of(input logic [15:0] v, input logic [1:0] d);
        return v[{d, 2'b00} +: 4];
    endfunction : digit_of

    // Adder operand steering; S_MUL_ADD and S_DIV_SUB use the adder their own way
    always_comb begin
        add_a = r.acc;
        add_b = r.opnd;
        add_sub = (r.op == OP_SUB_FROM_BITS);
        case (r.st)
            S_MUL_ADD: begin
                add_a = r.work;
                add_b = {16'h0000, r.acc[15:0]};
                add_sub = 1'b0;
            end
            S_DIV_SUB: begin
                add_a = r.work;
                add_b = {16'h0000, r.opnd[15:0]};
                add_sub = 1'b1;
            end
            default: begin
                add_a = r.acc;
                add_b = r.opnd;
                add_sub = (r.op == OP_SUB_FROM_BITS);
            end
        endcase
    end

    // Next-state logic
    always_comb begin
        r_nxt = r;
        r_nxt.done = 1'b0;
        r_nxt.illegal = 1'b0;
        r_nxt.rd_en = 1'b0;
        r_nxt.stk_wr = 1'b0;
        case (r.st)
            S_IDLE: begin
                // Loads only between operations, so results are never overrun
                if (acc_load_i) begin
                    r_nxt.acc = acc_load_data_i;
                end
                if (start_i) begin
                    if (cnt_ok(cmd_i.op, cmd_i.bit_cnt)) begin
                        r_nxt.op = cmd_i.op;
                        r_nxt.base = cmd_i.bit_addr[ADDR_W-1:0];
                        r_nxt.cnt = cmd_i.bit_cnt;
                        r_nxt.idx = 6'h00;
                        r_nxt.opnd = 32'h0000_0000;
                        r_nxt.busy = 1'b1;
                        r_nxt.st = S_REQ;
                    end else begin
                        // Refused: nothing changes, flags included
                        r_nxt.illegal = 1'b1;
                        r_nxt.done = 1'b1;
                    end
                end
            end
            S_REQ: begin
                // One read per bit; the memory answers in the next cycle
                r_nxt.rd_en = 1'b1;
                r_nxt.rd_addr = r.base + ADDR_W'(r.idx);
                r_nxt.st = S_CAP;
            end
            S_CAP: begin
                // Wait one more cycle for the data behind the read
                if (r.rd_en) begin
                    r_nxt.st = S_CAP;
                end else begin
                    r_nxt.opnd[r.idx[4:0]] = bit_rd_data_i;
                    r_nxt.idx = r.idx + 6'h01;
                    r_nxt.st = (r.idx + 6'h01 == r.cnt) ? S_EXEC : S_REQ;
                end
            end
            S_EXEC: begin
                case (r.op)
                    OP_ADD_FROM_BITS: begin
                        r_nxt.acc = add_sum;
                        r_nxt.flags.carry16_flag = add_c16;
                        r_nxt.flags.carry32_flag = add_c32;
                        r_nxt.flags.bad_bcd_flag = !(is_bcd32(r.acc) && is_bcd32(r.opnd));
                        r_nxt.st = S_FIN;
                    end
                    OP_SUB_FROM_BITS: begin
                        r_nxt.acc = add_sum;
                        r_nxt.flags.borrow16_flag = !add_c16;
                        r_nxt.flags.borrow32_flag = !add_c32;
                        r_nxt.flags.bad_bcd_flag = !(is_bcd32(r.acc) && is_bcd32(r.opnd));
                        r_nxt.st = S_FIN;
                    end
                    OP_MUL_FROM_BITS: begin
                        // Only the low four digits take part
                        r_nxt.flags.bad_bcd_flag = !(is_bcd32({16'h0000, r.acc[15:0]}) &&
                                                     is_bcd32(r.opnd));
                        r_nxt.work = 32'h0000_0000;
                        r_nxt.dig = `FBA_LOW_DIGIT_TOP;
                        r_nxt.st = S_MUL_SH;
                    end
                    default: begin
                        r_nxt.flags.bad_bcd_flag = !(is_bcd32({16'h0000, r.acc[15:0]}) &&
                                                     is_bcd32(r.opnd));
                        r_nxt.work = 32'h0000_0000;
                        r_nxt.quo = 16'h0000;
                        r_nxt.dig = `FBA_LOW_DIGIT_TOP;
                        r_nxt.st = S_DIV_SH;
                    end
                endcase
            end
            S_MUL_SH: begin
                // Times ten is a one-digit shift in BCD
                r_nxt.work = {r.work[27:0], 4'h0};
                r_nxt.rep = 4'h0;
                r_nxt.st = S_MUL_ADD;
            end
            S_MUL_ADD: begin
                // Repeated addition; a bad digit still ends within fifteen steps
                if (r.rep == digit_of(r.opnd[15:0], r.dig)) begin
                    if (r.dig == 2'h0) begin
                        r_nxt.acc = r.work;
                        r_nxt.st = S_FIN;
                    end else begin
                        r_nxt.dig = r.dig - 2'h1;
                        r_nxt.st = S_MUL_SH;
                    end
                end else begin
                    r_nxt.work = add_sum;
                    r_nxt.rep = r.rep + 4'h1;
                end
            end
            S_DIV_SH: begin
                // Bring down the next dividend digit
                r_nxt.work = {r.work[27:0], digit_of(r.acc[15:0], r.dig)};
                r_nxt.quo = {r.quo[11:0], 4'h0};
                r_nxt.st = S_DIV_SUB;
            end
            S_DIV_SUB: begin
                // Trial subtraction; no borrow means one more quotient count
                if (add_c32 && (r.opnd[15:0] != 16'h0000)) begin
                    r_nxt.work = add_sum;
                    r_nxt.quo = r.quo + 16'h0001;
                end else if (r.dig == 2'h0) begin
                    r_nxt.acc = {16'h0000, r.quo};
                    r_nxt.stk_data = r.work;
                    r_nxt.stk_wr = 1'b1;
                    r_nxt.st = S_FIN;
                end else begin
                    r_nxt.dig = r.dig - 2'h1;
                    r_nxt.st = S_DIV_SH;
                end
            end
            S_FIN: begin
                // Flags from the accumulator, then release the sequencer
                r_nxt.flags.zero_flag = (r.acc == 32'h0000_0000);
                r_nxt.flags.negative_flag = r.acc[31];
                r_nxt.done = 1'b1;
                r_nxt.busy = 1'b0;
                r_nxt.st = S_IDLE;
            end
            default: begin
                r_nxt.st = S_IDLE;
                r_nxt.busy = 1'b0;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '0;
            r.st <= S_IDLE;
            r.acc <= `FBA_ACC_RST;
            r.stk_data <= `FBA_STK_RST;
        end else begin
            r <= r_nxt;
        end
    end

    // Every output is a field of the state register
    assign busy_o = r.busy;
    assign done_o = r.done;
    assign illegal_o = r.illegal;
    assign acc_o = r.acc;
    assign bit_rd_en_o = r.rd_en;
    assign bit_rd_addr_o = r.rd_addr;
    assign stack_wr_o = r.stk_wr;
    assign stack_data_o = r.stk_data;
    assign flags_o = r.flags;

endmodule : formatted_bcd_arith_unit

`default_nettype wire

//--- tb/formatted_bcd_arith_unit_sva.sv
/* Checker of the formatted BCD unit: handshake, count refusal and flag relations.
   Assumes it is bound to formatted_bcd_arith_unit and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module formatted_bcd_arith_unit_chk
    import formatted_bcd_arith_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // Clock, reset, command
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire cmd_t cmd_i,
    input wire logic acc_load_i,
    // Observed results
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic illegal_o,
    input wire logic [31:0] acc_o,
    input wire logic bit_rd_en_o,
    input wire logic stack_wr_o,
    input wire flags_t flags_o
);
    default clocking cb_sys @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // Completion and refusal
    // A start in the done cycle may be refused at once, giving a second pulse
    a_done_single: assert property (done_o && !start_i |=> !done_o)
        else $error("done too long");
    a_illegal_done: assert property (illegal_o |-> done_o && !busy_o) else $error("lone illegal");
    a_zero_cnt: assert property (start_i && !busy_o && cmd_i.bit_cnt == 6'h00
        |=> done_o && illegal_o) else $error("count zero taken");
    a_wide_cnt: assert property (start_i && !busy_o && cmd_i.bit_cnt > 6'h20
        |=> illegal_o) else $error("count above 32 taken");
    a_narrow_cnt: assert property (start_i && !busy_o && cmd_i.bit_cnt > 6'h10
        && cmd_i.op inside {OP_MUL_FROM_BITS, OP_DIV_FROM_BITS} |=> illegal_o)
        else $error("count above 16 taken");
    a_one_cnt: assert property (start_i && !busy_o && cmd_i.bit_cnt == 6'h01
        |=> busy_o && !illegal_o) else $error("count one refused");
    // Flags follow the final accumulator
    a_zero_track: assert property (done_o && !illegal_o
        |-> flags_o.zero_flag == (acc_o == 32'h0000_0000)) else $error("zero flag wrong");
    a_neg_track: assert property (done_o && !illegal_o
        |-> flags_o.negative_flag == acc_o[31]) else $error("negative flag wrong");
    // Bit reads are spaced so each answer is taken alone
    a_read_space: assert property (bit_rd_en_o |=> !bit_rd_en_o [*2])
        else $error("bit reads too close");
    a_stack_done: assert property (stack_wr_o |=> done_o && !illegal_o)
        else $error("stack write not followed by done");
    // Nothing moves outside an operation or a load
    a_acc_quiet: assert property (!$stable(acc_o) |-> $past(busy_o) || $past(acc_load_i))
        else $error("acc changed idle");
    a_flag_quiet: assert property (!$stable(flags_o) |-> $past(busy_o))
        else $error("flags changed idle");
endmodule : formatted_bcd_arith_unit_chk

bind formatted_bcd_arith_unit formatted_bcd_arith_unit_chk #(.ADDR_W(ADDR_W)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i), .cmd_i(cmd_i),
    .acc_load_i(acc_load_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
    .acc_o(acc_o), .bit_rd_en_o(bit_rd_en_o), .stack_wr_o(stack_wr_o), .flags_o(flags_o));
`default_nettype wire

//--- tb/bit_mem_model.sv
/* Discrete bit memory seen by the unit: one bit per address.
   Assumes the bench fills mem directly; answers one cycle after a read. */
`timescale 1ns/1ps
`default_nettype none
module bit_mem_model #(
    parameter int ADDR_W = 16
) (
    // Read port
    input wire logic clk_sys_i,
    input wire logic rd_en_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic rd_data_o
);
    logic mem [2**ADDR_W];

    initial rd_data_o = 1'b0;
    // Answer once, then toggle so a sample one cycle late sees the bit inverted
    always @(posedge clk_sys_i) begin
        if (rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end else begin
            rd_data_o <= ~rd_data_o;
        end
    end
endmodule : bit_mem_model
`default_nettype wire

//--- tb/test_formatted_bcd_arith_unit.sv
/* Self-checking bench of the formatted BCD unit with a bit memory model.
   Assumes the package, the design and the checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module test_formatted_bcd_arith_unit;
    import formatted_bcd_arith_pkg::*;
    logic clk_sys_i, rst_i, start_i, acc_load_i, busy_o, done_o, illegal_o;
    logic bit_rd_en_o, bit_rd_data_i, stack_wr_o, stack_seen;
    logic [15:0] bit_rd_addr_o;
    logic [31:0] acc_load_data_i, acc_o, stack_data_o;
    cmd_t cmd_i;
    flags_t flags_o, exp_f;
    int fail_count = 0;
    int n_tests = 0;

    formatted_bcd_arith_unit #(.ADDR_W(16)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .start_i(start_i), .cmd_i(cmd_i), .busy_o(busy_o), .done_o(done_o),
        .illegal_o(illegal_o), .acc_load_i(acc_load_i), .acc_load_data_i(acc_load_data_i),
        .acc_o(acc_o), .bit_rd_en_o(bit_rd_en_o), .bit_rd_addr_o(bit_rd_addr_o),
        .bit_rd_data_i(bit_rd_data_i), .stack_wr_o(stack_wr_o),
        .stack_data_o(stack_data_o), .flags_o(flags_o));
    bit_mem_model #(.ADDR_W(16)) mem_u (.clk_sys_i(clk_sys_i), .rd_en_i(bit_rd_en_o),
        .rd_addr_i(bit_rd_addr_o), .rd_data_o(bit_rd_data_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic conclude();
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // Comparisons by kind of result
    task automatic chk32(input string name, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : chk32
    task automatic chk1(input string name, input logic e, input logic g);
        chk32(name, {31'h0, e}, {31'h0, g});
    endtask : chk1
    task automatic chk_flags(input flags_t e);
        chk32("flags", {25'h0, e}, {25'h0, flags_o});
    endtask : chk_flags

    task automatic load(input logic [31:0] v);
        @(posedge clk_sys_i);
        acc_load_i <= 1'b1;
        acc_load_data_i <= v;
        @(posedge clk_sys_i);
        acc_load_i <= 1'b0;
    endtask : load

    // Ones above the count must never reach the operand
    task automatic run(input op_t op, input logic [5:0] cnt, input logic [31:0] v);
        int n;
        for (int i = 0; i < 48; i++) mem_u.mem[16'h0040 + i] = (i < cnt && i < 32) ? v[i] : 1'b1;
        @(posedge clk_sys_i);
        start_i <= 1'b1;
        cmd_i <= '{op, 16'h0040, cnt};
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        stack_seen = 1'b0;
        for (n = 0; n < 400; n++) begin
            #1;
            if (stack_wr_o === 1'b1) stack_seen = 1'b1;
            if (done_o === 1'b1) break;
            @(posedge clk_sys_i);
        end
        chk1("done", 1'b1, done_o);
        chk1("busy", 1'b0, busy_o);
    endtask : run

    // cb holds carry16, carry32, borrow16, borrow32 as they must stand afterwards
    task automatic step(input op_t op, input logic [5:0] cnt, input logic [31:0] v,
                        input logic [31:0] e_acc, input logic [3:0] cb);
        run(op, cnt, v);
        exp_f = {e_acc == 32'h0, e_acc[31], cb, 1'b0};
        chk32("acc", e_acc, acc_o);
        chk_flags(exp_f);
        chk1("illegal", 1'b0, illegal_o);
    endtask : step

    initial begin
        rst_i = 1'b1;
        start_i = 1'b0;
        acc_load_i = 1'b0;
        acc_load_data_i = 32'h0;
        cmd_i = '0;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        load(32'h0);
        run(OP_ADD_FROM_BITS, 6'h04, 32'hA);
        chk1("bad_bcd", 1'b1, flags_o.bad_bcd_flag);
        load(32'h19);
        step(OP_ADD_FROM_BITS, 6'h04, 32'h7, 32'h26, 4'h0);
        load(32'h9999_9999);
        step(OP_ADD_FROM_BITS, 6'h01, 32'h1, 32'h0, 4'hC);
        load(32'h9999);
        step(OP_ADD_FROM_BITS, 6'h20, 32'h1, 32'h0001_0000, 4'h8);
        load(32'h5);
        step(OP_SUB_FROM_BITS, 6'h03, 32'h7, 32'h9999_9998, 4'hB);
        load(32'h0001_0000);
        step(OP_SUB_FROM_BITS, 6'h01, 32'h1, 32'h9999, 4'hA);
        load(32'h12);
        step(OP_MUL_FROM_BITS, 6'h02, 32'h3, 32'h36, 4'hA);
        load(32'h1234);
        step(OP_MUL_FROM_BITS, 6'h10, 32'h2, 32'h2468, 4'hA);
        load(32'h17);
        step(OP_DIV_FROM_BITS, 6'h03, 32'h5, 32'h3, 4'hA);
        chk32("stack", 32'h2, stack_data_o);
        chk1("stack_wr", 1'b1, stack_seen);
        load(32'h1234_5678);
        step(OP_DIV_FROM_BITS, 6'h03, 32'h4, 32'h1419, 4'hA);
        // Refused counts leave everything as it was
        for (int k = 0; k < 4; k++) begin
            run(op_t'(k), (k == 0) ? 6'h00 : ((k == 1) ? 6'h21 : 6'h11), 32'h0);
            chk1("illegal", 1'b1, illegal_o);
            chk32("acc", 32'h1419, acc_o);
            chk_flags(exp_f);
        end
        conclude();
    end

    // Whole run takes well under this span
    initial begin
        #300000;
        fail_count++;
        conclude();
    end
endmodule : test_formatted_bcd_arith_unit
`default_nettype wire
